//--- hw/udc_counter.sv
// Purpose: Up/down event counter with target, terminal flag and sticky wrap flag.
// Assumes: event_input is synchronous to aclk; one AXI4-Lite master.
// Notes: Counting logic has one clock; no buffering.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - With count_gate low and reset control 0 the count holds and events are ignored; it resets to 0.
// - A direction setting of 0, the reset value, selects up counting.
// - A direction setting of 1 selects down counting, each event lowering the count by one.
// - A low-to-high edge of event_input is one event and adds one when counting up.
// - Counting up, terminal_reached_flag is high once the count equals terminal_value.
// - Counting up at the target, an event loads zero, sets the wrap flag and drops the terminal flag.
// - Counting down, the count falls to zero and the terminal flag rises at zero.
// - Counting down at zero, an event loads the target, sets the wrap flag and drops the terminal flag.
// - The terminal and wrap flags are read-only status bits, and wrap stays set until cleared.
// - terminal_value is writable up to 99999 and resets to 9999.
// - tally_value is a read-only 17-bit count from 0 to 99999.
// - While reset control is 1 the count is 0 up or the target down, and wrap is cleared.
// - Writing 1 to wrap_flag_clear clears the wrap flag without touching the count.
module udc_counter
	import udc_pkg::*;
#(
	parameter int CNT_W = UDC_CNT_W
)
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Count source.
	input wire logic event_input,
	// Status pins.
	output logic [CNT_W-1:0] tally_value,
	output logic terminal_reached_flag,
	output logic wrap_flag,
	output logic irq,
	// AXI4-Lite write address.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == UDC_OFF_CTRL) || (a == UDC_OFF_TARGET) || (a == UDC_OFF_COUNT)
			|| (a == UDC_OFF_STATUS) || (a == UDC_OFF_IRQ_STAT) || (a == UDC_OFF_IRQ_MASK);
	endfunction

	udc_ctrl_s ctrl;
	logic [CNT_W-1:0] terminal_value;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic event_prev;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Write address and data are latched separately so either may come first.
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_go = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
	wire wr_ok = wr_go && is_mapped(wr_addr);
	wire wr_ctrl = wr_ok && (wr_addr == UDC_OFF_CTRL) && wr_strb[0];
	wire wr_tgt = wr_ok && (wr_addr == UDC_OFF_TARGET);
	wire wr_istat = wr_ok && (wr_addr == UDC_OFF_IRQ_STAT) && wr_strb[0];
	wire wr_imask = wr_ok && (wr_addr == UDC_OFF_IRQ_MASK) && wr_strb[0];
	// Lanes 0 to 2 are merged at 24 bits so a value up to 24 bits is clamped instead of wrapping; lane 3 is ignored.
	wire [23:0] tgt_wide = {wr_strb[2] ? wr_data[23:16] : 8'(terminal_value >> 16),
		wr_strb[1] ? wr_data[15:8] : terminal_value[15:8],
		wr_strb[0] ? wr_data[7:0] : terminal_value[7:0]};
	// Targets above the range are clamped rather than refused, so the count stays bounded.
	wire [CNT_W-1:0] tgt_next = (tgt_wide > 24'(UDC_TARGET_MAX)) ? CNT_W'(UDC_TARGET_MAX)
		: CNT_W'(tgt_wide);

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Counting datapath.
	// The previous sample resets low, so a source already high looks like an edge; the gate
	// is off after reset, which keeps that false edge from counting.
	wire edge_seen = event_input && !event_prev;
	wire step = edge_seen && ctrl.count_gate && !ctrl.hold_reset;
	wire at_end = ctrl.count_down ? (tally_value == '0) : (tally_value == terminal_value);
	wire wrap_now = step && at_end;
	wire wrap_clear = wr_ctrl && wr_data[UDC_CTRL_WCLR];
	// Reset control is a level: it forces the count every cycle and follows target edits.
	wire [CNT_W-1:0] next_tally = ctrl.hold_reset ? (ctrl.count_down ? terminal_value : '0)
		: !step ? tally_value
		: wrap_now ? (ctrl.count_down ? terminal_value : '0)
		: ctrl.count_down ? tally_value - 1'b1 : tally_value + 1'b1;
	wire next_wrap = wrap_now || (!ctrl.hold_reset && !wrap_clear && wrap_flag);
	wire next_term = ctrl.count_down ? (next_tally == '0) : (next_tally == terminal_value);

	// Terminal flag follows the count; it also tracks target edits made while stopped.
	assign terminal_reached_flag = ctrl.count_down ? (tally_value == '0)
		: (tally_value == terminal_value);
	assign irq = |(irq_stat & irq_mask);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= '0;
			terminal_value <= CNT_W'(UDC_TARGET_RST);
			tally_value <= '0;
			wrap_flag <= 1'b0;
			event_prev <= 1'b0;
		end
		else
		begin
			event_prev <= event_input;
			tally_value <= next_tally;
			wrap_flag <= next_wrap;
			if (wr_ctrl)
			begin
				ctrl.count_gate <= wr_data[UDC_CTRL_GATE];
				ctrl.count_down <= wr_data[UDC_CTRL_DIR];
				ctrl.hold_reset <= wr_data[UDC_CTRL_RESET];
			end
			if (wr_tgt)
				terminal_value <= tgt_next;
		end
	end

	// Interrupt status: terminal arrival and wrap events; set beats write-one-to-clear.
	wire term_rise = !terminal_reached_flag && next_term && step;
	wire [1:0] irq_set = {wrap_now, term_rise};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_stat <= '0;
			irq_mask <= '0;
		end
		else
		begin
			irq_stat <= irq_set | (irq_stat & ~(wr_istat ? wr_data[1:0] : 2'h0));
			if (wr_imask)
				irq_mask <= wr_data[1:0];
		end
	end

	// Write channel bookkeeping.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= UDC_RESP_OKAY;
		end
		else
		begin
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(wr_addr) ? UDC_RESP_OKAY : UDC_RESP_SLVERR;
			end
			else
			begin
				if (aw_take)
				begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (w_take)
				begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel; the control reset bit reads back, the clear bit reads as zero.
	wire [31:0] rd_word =
		(s_axi_araddr == UDC_OFF_CTRL) ? 32'({ctrl.hold_reset, ctrl.count_down, ctrl.count_gate})
		: (s_axi_araddr == UDC_OFF_TARGET) ? 32'(terminal_value)
		: (s_axi_araddr == UDC_OFF_COUNT) ? 32'(tally_value)
		: (s_axi_araddr == UDC_OFF_STATUS) ? 32'({wrap_flag, terminal_reached_flag})
		: (s_axi_araddr == UDC_OFF_IRQ_STAT) ? 32'(irq_stat)
		: (s_axi_araddr == UDC_OFF_IRQ_MASK) ? 32'(irq_mask)
		: 32'h0;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= UDC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? UDC_RESP_OKAY : UDC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Checks.
	sequence s_up_at_end;
		ctrl.count_gate && !ctrl.count_down && !ctrl.hold_reset
			&& tally_value == terminal_value;
	endsequence
	sequence s_rise;
		!event_prev && event_input;
	endsequence

	a_gate_holds_count: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl.count_gate && !ctrl.hold_reset && !wr_ctrl |=> $stable(tally_value))
		else $error("count moved while gate was low");
	a_up_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
		step && !ctrl.count_down && !at_end |=> tally_value == $past(tally_value) + 1'b1)
		else $error("up count did not advance by one");
	a_down_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
		step && ctrl.count_down && !at_end |=> tally_value == $past(tally_value) - 1'b1)
		else $error("down count did not fall by one");
	a_up_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s_up_at_end ##0 s_rise |=> tally_value == '0 && wrap_flag)
		else $error("up wrap did not load zero and set wrap");
	a_down_wrap_target: assert property (@(posedge aclk) disable iff (!aresetn)
		step && ctrl.count_down && tally_value == '0
			|=> tally_value == $past(terminal_value) && wrap_flag)
		else $error("down wrap did not load target");
	a_term_up_equal: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl.count_down && tally_value == terminal_value |-> terminal_reached_flag)
		else $error("terminal flag missing at target");
	a_term_down_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.count_down && terminal_reached_flag |-> tally_value == '0)
		else $error("terminal flag wrong while counting down");
	a_wrap_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap_flag && !wrap_clear && !ctrl.hold_reset |=> wrap_flag)
		else $error("wrap flag dropped without a clear");
	a_reset_forces: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.hold_reset
			|=> !wrap_flag && tally_value == ($past(ctrl.count_down) ? $past(terminal_value) : '0))
		else $error("reset control did not force count");
	a_clear_keeps_count: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap_clear && !wrap_now && !ctrl.hold_reset && !step |=> !wrap_flag && $stable(tally_value))
		else $error("clear disturbed count or kept wrap");
	a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap_now && wrap_clear |=> wrap_flag)
		else $error("clear beat a simultaneous wrap");
	a_target_range: assert property (@(posedge aclk) disable iff (!aresetn)
		terminal_value <= CNT_W'(UDC_TARGET_MAX) && tally_value <= CNT_W'(UDC_TARGET_MAX))
		else $error("target or count out of range");
	a_reset_defaults: assert property (@(posedge aclk)
		!aresetn |=> ctrl == '0 && terminal_value == CNT_W'(UDC_TARGET_RST)
			&& tally_value == '0 && !wrap_flag)
		else $error("bus reset left a setting off its default");
	a_term_up_arrive: assert property (@(posedge aclk) disable iff (!aresetn)
		step && !ctrl.count_down && !wr_ctrl && !wr_tgt
			&& tally_value + 1'b1 == terminal_value |=> terminal_reached_flag)
		else $error("up count reaching target did not raise the terminal flag");
	a_down_arrive_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		step && ctrl.count_down && tally_value == CNT_W'(1) && !wr_ctrl
			|=> tally_value == '0 && terminal_reached_flag)
		else $error("down count reaching zero did not raise the terminal flag");
	a_reset_beats_event: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.hold_reset && ctrl.count_gate && edge_seen
			|=> tally_value == ($past(ctrl.count_down) ? $past(terminal_value) : '0))
		else $error("an event moved the count under reset control");
	a_wrap_needs_event: assert property (@(posedge aclk) disable iff (!aresetn)
		!wrap_flag && !wrap_now |=> !wrap_flag)
		else $error("wrap flag rose without a wrap");
	a_dir_keeps_count: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl && !ctrl.hold_reset && !step |=> $stable(tally_value))
		else $error("a control write moved the count");
	// Interrupt status must keep each event even when software clears it in the same cycle.
	a_irq_wrap_set: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap_now |=> irq_stat[UDC_IRQ_WRAP])
		else $error("wrap event missing from interrupt status");
	a_irq_term_set: assert property (@(posedge aclk) disable iff (!aresetn)
		term_rise |=> irq_stat[UDC_IRQ_TERM])
		else $error("terminal arrival missing from interrupt status");
endmodule

//--- hw/udc_pkg.sv
// Purpose: Shared constants and types for the up/down target counter.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses of aligned words.
package udc_pkg;
	localparam int UDC_CNT_W = 17;
	localparam logic [16:0] UDC_TARGET_MAX = 17'h1869f;
	localparam logic [16:0] UDC_TARGET_RST = 17'h0270f;
	localparam logic [7:0] UDC_OFF_CTRL = 8'h00;
	localparam logic [7:0] UDC_OFF_TARGET = 8'h04;
	localparam logic [7:0] UDC_OFF_COUNT = 8'h08;
	localparam logic [7:0] UDC_OFF_STATUS = 8'h0c;
	localparam logic [7:0] UDC_OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] UDC_OFF_IRQ_MASK = 8'h14;
	localparam int UDC_CTRL_GATE = 0;
	localparam int UDC_CTRL_DIR = 1;
	localparam int UDC_CTRL_RESET = 2;
	localparam int UDC_CTRL_WCLR = 3;
	localparam int UDC_ST_TERM = 0;
	localparam int UDC_ST_WRAP = 1;
	localparam int UDC_IRQ_TERM = 0;
	localparam int UDC_IRQ_WRAP = 1;
	localparam logic [1:0] UDC_RESP_OKAY = 2'h0;
	localparam logic [1:0] UDC_RESP_SLVERR = 2'h2;
	typedef struct packed
	{
		logic count_gate;
		logic count_down;
		logic hold_reset;
	} udc_ctrl_s;
endpackage

//--- bench/udc_event_src.sv
// Purpose: Wired digital source that feeds event pulses into the counter.
// Assumes: One pulse for each fire request, taken only while idle.
// Notes: With slow set each phase lasts three cycles instead of one.
`timescale 1ns/1ps
module udc_event_src
(
	// Clock.
	input wire logic aclk,
	// Request side.
	input wire logic fire,
	input wire logic slow,
	output logic busy,
	// Wired level into the counter.
	output logic event_input
);
	logic [2:0] phase = 3'h0;
	logic level = 1'b0;
	wire [2:0] half = slow ? 3'h3 : 3'h1;
	assign busy = (phase != 3'h0);
	assign event_input = level;
	// Both phases last at least one sample, or the counter would miss the edge.
	always_ff @(posedge aclk)
	begin
		if (!busy && fire)
		begin
			level <= 1'b1;
			phase <= slow ? 3'h5 : 3'h1;
		end
		else if (busy)
		begin
			phase <= phase - 3'h1;
			if (phase == half)
				level <= 1'b0;
		end
	end
endmodule

//--- bench/up_down_target_counter_bench.sv
// Purpose: Self-checking bench for the up/down target counter.
// Assumes: Register map as the package declares; the master waits for every answer.
// Notes: Events come from the wired source model.
`timescale 1ns/1ps
module up_down_target_counter_bench
	import udc_pkg::*;
;
	logic aclk, aresetn, fire, slow, busy, ev, term, wrap, irq;
	logic [16:0] tally;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int n_mismatch = 0;
	int checks = 0;
	udc_event_src u_udc_event_src (.aclk(aclk), .fire(fire), .slow(slow), .busy(busy),
		.event_input(ev));
	udc_counter u_udc_counter (.aclk(aclk), .aresetn(aresetn), .event_input(ev),
		.tally_value(tally), .terminal_reached_flag(term), .wrap_flag(wrap), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Bus master: hold each channel until its ready, answer ready held until the reply.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		chk("rdata", rdata, ed);
		@(posedge aclk);
	endtask
	// The source ignores requests while busy, so wait for it before firing; the count moves
	// one edge after the source raises its level and is read at the edge after that.
	task automatic pulse(input logic s);
		while (busy)
			@(posedge aclk);
		slow <= s;
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic pins(input logic [16:0] c, input logic t, input logic w);
		chk("tally_value", {15'h0, tally}, {15'h0, c});
		chk("terminal_flag", {31'h0, term}, {31'h0, t});
		chk("wrap_flag", {31'h0, wrap}, {31'h0, w});
	endtask
	initial
	begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		{aresetn, fire, slow, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(UDC_OFF_CTRL, 32'h0, UDC_RESP_OKAY);
		rd(UDC_OFF_TARGET, {15'h0, UDC_TARGET_RST}, UDC_RESP_OKAY);
		rd(UDC_OFF_STATUS, 32'h0, UDC_RESP_OKAY);
		rd(8'h18, 32'h0, UDC_RESP_SLVERR);
		wr(8'h18, 32'h1, UDC_RESP_SLVERR);
		wr(UDC_OFF_COUNT, 32'h5, UDC_RESP_OKAY);
		rd(UDC_OFF_COUNT, 32'h0, UDC_RESP_OKAY);
		pulse(1'b0);
		pins(17'h0, 1'b0, 1'b0);
		wr(UDC_OFF_TARGET, 32'h3, UDC_RESP_OKAY);
		wr(UDC_OFF_CTRL, 32'h1, UDC_RESP_OKAY);
		for (int i = 1; i <= 3; i++)
		begin
			pulse(i == 2);
			pins(17'(i), i == 3, 1'b0);
		end
		rd(UDC_OFF_STATUS, 32'h1, UDC_RESP_OKAY);
		pulse(1'b0);
		pins(17'h0, 1'b0, 1'b1);
		rd(UDC_OFF_IRQ_STAT, 32'h3, UDC_RESP_OKAY);
		chk("irq", {31'h0, irq}, 32'h0);
		pulse(1'b0);
		pins(17'h1, 1'b0, 1'b1);
		wr(UDC_OFF_IRQ_MASK, 32'h2, UDC_RESP_OKAY);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(UDC_OFF_IRQ_STAT, 32'h2, UDC_RESP_OKAY);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(UDC_OFF_CTRL, 32'h9, UDC_RESP_OKAY);
		pins(17'h1, 1'b0, 1'b0);
		rd(UDC_OFF_CTRL, 32'h1, UDC_RESP_OKAY);
		wr(UDC_OFF_TARGET, 32'h1ffff, UDC_RESP_OKAY);
		rd(UDC_OFF_TARGET, {15'h0, UDC_TARGET_MAX}, UDC_RESP_OKAY);
		wr(UDC_OFF_TARGET, 32'h2, UDC_RESP_OKAY);
		pulse(1'b0);
		pulse(1'b0);
		pins(17'h0, 1'b0, 1'b1);
		wr(UDC_OFF_CTRL, 32'h7, UDC_RESP_OKAY);
		pins(17'h2, 1'b0, 1'b0);
		pulse(1'b0);
		pins(17'h2, 1'b0, 1'b0);
		wr(UDC_OFF_CTRL, 32'h3, UDC_RESP_OKAY);
		pulse(1'b0);
		pins(17'h1, 1'b0, 1'b0);
		pulse(1'b1);
		pins(17'h0, 1'b1, 1'b0);
		pulse(1'b0);
		pins(17'h2, 1'b0, 1'b1);
		rd(UDC_OFF_STATUS, 32'h2, UDC_RESP_OKAY);
		wr(UDC_OFF_CTRL, 32'h5, UDC_RESP_OKAY);
		pins(17'h0, 1'b0, 1'b0);
		wr(UDC_OFF_CTRL, 32'h1, UDC_RESP_OKAY);
		pulse(1'b0);
		pulse(1'b0);
		pins(17'h2, 1'b1, 1'b0);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		wr(UDC_OFF_CTRL, 32'h9, UDC_RESP_OKAY);
		pins(17'h0, 1'b0, 1'b1);
		tally_and_finish();
	end
endmodule
